// ===== bench/pcr_phase_calibration_regs_tb_top.sv
// self-checking bench for the phase calibration register bank
`timescale 1ns/1ps
module pcr_phase_calibration_regs_tb_top import pcr_pkg::*;;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [ADDR_W-1:0] reg_addr = '0;
   logic [DATA_W-1:0] reg_wr_data = '0;
   logic reg_wr_en = 1'b0;
   logic reg_rd_en = 1'b0;
   logic [DATA_W-1:0] reg_rd_data;
   logic compute_start = 1'b0;
   logic [DATA_W-1:0] rms = '0;
   pcr_applied_s applied;
   logic multipoint_enable;
   logic [DATA_W-1:0] m [NUM_SLOTS];
   int error_cnt = 0;
   int comparisons = 0;
   int r;

   always #2.5 ref_clk = ~ref_clk;

   pcr_phase_calibration_regs dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wr_data(reg_wr_data), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
      .compute_start(compute_start), .phase_a_current_rms(rms), .phase_b_current_rms(rms),
      .applied(applied), .multipoint_enable(multipoint_enable));

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : final_report

   task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: value %h expected %h", $time, got, exp);
      end
   endtask : chk

   // expected hand-over built from the shadow copy, corr slot and selected gain
   task automatic chk_app(input int pc, input logic [DATA_W-1:0] mg);
      pcr_applied_s e;
      e[DATA_W*16 +: DATA_W] = m[pc];
      for (int s = SLOT_VGAIN; s <= SLOT_PHASE_B_CURRENT_GAIN; s++) begin
         e[DATA_W*(20-s) +: DATA_W] = m[s];
      end
      e[0 +: DATA_W] = mg;
      comparisons++;
      if (applied !== e) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: applied values differ", $time);
      end
   endtask : chk_app

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wr_data <= d;
      reg_wr_en <= 1'b1;
      @(posedge ref_clk);
      reg_wr_en <= 1'b0;
   endtask : wr

   task automatic wrs(input int s, input logic [DATA_W-1:0] d);
      wr(OFFSETS[s], d);
      m[s] = d;
   endtask : wrs

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd_en <= 1'b1;
      @(posedge ref_clk);
      reg_rd_en <= 1'b0;
      #1 chk(reg_rd_data, exp);
   endtask : rd

   task automatic comp(input logic [DATA_W-1:0] v);
      @(posedge ref_clk);
      compute_start <= 1'b1;
      rms <= v;
      @(posedge ref_clk);
      compute_start <= 1'b0;
      #1;
   endtask : comp

   initial begin : main
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      for (int s = 0; s < NUM_SLOTS; s++) begin
         m[s] = RESET_VAL;
         rd(OFFSETS[s], RESET_VAL);
      end
      $display("test reset values done");
      for (int s = 0; s <= SLOT_MGAIN0 + 5; s++) begin
         wrs(s, 32'hA500_0000 | (DATA_W'(s) << 8) | DATA_W'(s));
         rd(OFFSETS[s], m[s]);
      end
      wr(10'h019, 32'hFFFF_FFFF);
      rd(10'h019, '0);
      wr(OFF_STATUS, 32'hFFFF_FFFF);
      rd(OFF_STATUS, '0);
      $display("test write readback done");
      comp('0);
      chk_app(0, '0);
      // write landing on the same edge as the computation start
      @(posedge ref_clk);
      reg_addr <= OFFSETS[SLOT_PGAIN];
      reg_wr_data <= 32'h0BAD_CAFE;
      reg_wr_en <= 1'b1;
      compute_start <= 1'b1;
      @(posedge ref_clk);
      reg_wr_en <= 1'b0;
      compute_start <= 1'b0;
      #1 chk_app(0, '0);
      m[SLOT_PGAIN] = 32'h0BAD_CAFE;
      comp('0);
      chk_app(0, '0);
      $display("test hand-over done");
      for (int i = 0; i < NUM_THR; i++) begin
         wrs(SLOT_THR_LO0 + i, 32'h0000_0080);
         wrs(SLOT_THR_HI0 + i, 32'h0000_0100);
      end
      wrs(SLOT_CONFIG, 32'h0000_0001);
      // config bit lands on the write edge; look after it settles
      #1 chk(DATA_W'(multipoint_enable), 32'h0000_0001);
      r = 0;
      // one region step per computation, saturating at the top
      repeat (6) begin
         comp(32'h0000_0200);
         if (r < 5) r++;
         chk_app(r > 4 ? 4 : r, m[SLOT_MGAIN0 + r]);
         rd(OFF_STATUS, DATA_W'(r) | (DATA_W'(r) << 3));
      end
      wrs(SLOT_CONFIG, '0);
      #1 chk(DATA_W'(multipoint_enable), '0);
      comp(32'h0000_0200);
      chk_app(0, '0);
      wrs(SLOT_CONFIG, 32'h0000_0001);
      repeat (6) begin
         comp('0);
         if (r > 0) r--;
         chk_app(r > 4 ? 4 : r, m[SLOT_MGAIN0 + r]);
      end
      // region 0 held, then region 1 held between the thresholds
      comp('0);
      chk_app(0, m[SLOT_MGAIN0]);
      comp(32'h0000_0200);
      chk_app(1, m[SLOT_MGAIN0 + 1]);
      comp(32'h0000_00C0);
      chk_app(1, m[SLOT_MGAIN0 + 1]);
      $display("test multipoint done");
      final_report();
   end

   // whole run is well under 1000 cycles
   initial begin : watchdog
      #20000;
      error_cnt++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      final_report();
   end
endmodule : pcr_phase_calibration_regs_tb_top

// ===== rtl/pcr_phase_calibration_regs.sv
// phase calibration register bank with multipoint selection and per-computation hand-over
`timescale 1ns/1ps
//
// Function
// - multipoint off: only phase corr 0 applies
// - multipoint on: rms vs thresholds picks phase corr
// - multipoint on: rms picks one of six gains
// - power gain scales all six power results
// - separate current and voltage gain registers
// - filter and fundamental rms offsets, voltage/current
// - half-cycle and multicycle rms offsets
// - four distinct power offset registers
module pcr_phase_calibration_regs
   import pcr_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wr_data,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   output logic [DATA_W-1:0] reg_rd_data,
   // datapath side
   input wire logic compute_start,
   input wire logic [DATA_W-1:0] phase_a_current_rms,
   input wire logic [DATA_W-1:0] phase_b_current_rms,
   output pcr_applied_s applied,
   output logic multipoint_enable
);

   logic [DATA_W-1:0] bank_reg [NUM_SLOTS];
   logic [NUM_SLOTS-1:0] hit;
   logic [DATA_W-1:0] rd_mux;
   pcr_region_t region_reg [2];
   pcr_region_t region_next [2];
   logic [DATA_W-1:0] rms_in [2];
   logic [2:0] pcorr_idx;
   pcr_applied_s applied_reg;
   pcr_applied_s applied_next;

   assign rms_in[0] = phase_a_current_rms;
   assign rms_in[1] = phase_b_current_rms;
   assign multipoint_enable = bank_reg[SLOT_CONFIG][CFG_MULTIPOINT_ENABLE_BIT];

   // one storage word per slot; decode is a straight offset compare
   generate
      for (genvar s = 0; s < NUM_SLOTS; s++) begin : g_slot
         assign hit[s] = (reg_addr == OFFSETS[s]);
         always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
               bank_reg[s] <= RESET_VAL;
            end else if (reg_wr_en && hit[s]) begin
               bank_reg[s] <= reg_wr_data;
            end
         end
      end
   endgenerate

   // unmapped offsets read as zero, writes to them are dropped
   always_comb begin
      rd_mux = RESET_VAL;
      for (int s = 0; s < NUM_SLOTS; s++) begin
         if (hit[s]) begin
            rd_mux = bank_reg[s];
         end
      end
      if (reg_addr == OFF_STATUS) begin
         rd_mux = {26'h000_0000, region_reg[1], region_reg[0]};
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rd_data <= RESET_VAL;
      end else if (reg_rd_en) begin
         reg_rd_data <= rd_mux;
      end else begin
         reg_rd_data <= RESET_VAL;
      end
   end

   // amplitude region per phase; hysteresis between low and high thresholds
   // keeps the pick from chattering when rms sits on a boundary
   generate
      for (genvar p = 0; p < 2; p++) begin : g_region
         always_comb begin
            region_next[p] = region_reg[p];
            if (region_reg[p] < 3'(NUM_THR)
                && rms_in[p] > bank_reg[SLOT_THR_HI0 + int'(region_reg[p])]) begin
               region_next[p] = region_reg[p] + 3'd1;
            end else if (region_reg[p] != 3'd0
                && rms_in[p] < bank_reg[SLOT_THR_LO0 + int'(region_reg[p]) - 1]) begin
               region_next[p] = region_reg[p] - 3'd1;
            end
         end
         always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
               region_reg[p] <= 3'd0;
            end else if (compute_start) begin
               region_reg[p] <= region_next[p];
            end
         end
      end
   endgenerate

   // five phase values cover six regions: the top two share the last one
   assign pcorr_idx = (region_next[0] > 3'(NUM_PCORR - 1)) ? 3'(NUM_PCORR - 1) : region_next[0];

   always_comb begin
      applied_next = applied_reg;
      if (compute_start) begin
         if (multipoint_enable) begin
            applied_next.phase_a_phase_corr = bank_reg[SLOT_PCORR0 + int'(pcorr_idx)];
            applied_next.phase_b_multipoint_gain = bank_reg[SLOT_MGAIN0 + int'(region_next[1])];
         end else begin
            applied_next.phase_a_phase_corr = bank_reg[SLOT_PCORR0];
            applied_next.phase_b_multipoint_gain = RESET_VAL;
         end
         applied_next.phase_a_voltage_gain = bank_reg[SLOT_VGAIN];
         applied_next.phase_b_current_gain = bank_reg[SLOT_PHASE_B_CURRENT_GAIN];
         applied_next.phase_a_power_gain = bank_reg[SLOT_PGAIN];
         applied_next.phase_a_current_rms_offset = bank_reg[SLOT_IRMSOS];
         applied_next.phase_a_voltage_rms_offset = bank_reg[SLOT_VRMSOS];
         applied_next.phase_a_fund_current_rms_offset = bank_reg[SLOT_IFRMSOS];
         applied_next.phase_a_fund_voltage_rms_offset = bank_reg[SLOT_VFRMSOS];
         applied_next.phase_a_half_cycle_voltage_rms_offset = bank_reg[SLOT_VRMSONEOS];
         applied_next.phase_a_half_cycle_current_rms_offset = bank_reg[SLOT_IRMSONEOS];
         applied_next.phase_a_multicycle_voltage_rms_offset = bank_reg[SLOT_VRMS1012OS];
         applied_next.phase_a_multicycle_current_rms_offset = bank_reg[SLOT_IRMS1012OS];
         applied_next.phase_a_active_power_offset = bank_reg[SLOT_WATTOS];
         applied_next.phase_a_reactive_power_offset = bank_reg[SLOT_VAROS];
         applied_next.phase_a_fund_active_power_offset = bank_reg[SLOT_FWATTOS];
         applied_next.phase_a_fund_reactive_power_offset = bank_reg[SLOT_FVAROS];
      end
   end

   // values held for the whole computation so a mid-computation write cannot tear it
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         applied_reg <= '0;
      end else begin
         applied_reg <= applied_next;
      end
   end

   assign applied = applied_reg;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   pcorr_single_a: assert property (
      compute_start && !multipoint_enable |=> applied.phase_a_phase_corr == $past(bank_reg[SLOT_PCORR0]))
      else $error("phase corr not slot 0 with multipoint off");

   region_step_a: assert property (
      compute_start && region_reg[0] == 3'd0 && phase_a_current_rms > bank_reg[SLOT_THR_HI0]
      |=> region_reg[0] == 3'd1)
      else $error("phase a region did not rise above high threshold");

   pcorr_pick_a: assert property (
      compute_start && multipoint_enable && region_reg[0] == 3'd1
      && phase_a_current_rms <= bank_reg[SLOT_THR_HI0 + 1] && phase_a_current_rms >= bank_reg[SLOT_THR_LO0]
      |=> applied.phase_a_phase_corr == $past(bank_reg[SLOT_PCORR0 + 1]))
      else $error("phase corr pick wrong in region 1");

   gain_off_a: assert property (
      compute_start && !multipoint_enable |=> applied.phase_b_multipoint_gain == 32'h0000_0000)
      else $error("multipoint gain applied while disabled");

   gain_pick_a: assert property (
      compute_start && multipoint_enable && region_reg[1] == 3'd0
      && phase_b_current_rms <= bank_reg[SLOT_THR_HI0]
      |=> applied.phase_b_multipoint_gain == $past(bank_reg[SLOT_MGAIN0]))
      else $error("multipoint gain pick wrong in region 0");

   power_gain_a: assert property (
      reg_wr_en && reg_addr == OFFSETS[SLOT_PGAIN] ##1 compute_start
      |=> applied.phase_a_power_gain == $past(reg_wr_data, 2))
      else $error("power gain not carried to computation");

   split_gains_a: assert property (
      compute_start |=> applied.phase_a_voltage_gain == $past(bank_reg[SLOT_VGAIN])
      && applied.phase_b_current_gain == $past(bank_reg[SLOT_PHASE_B_CURRENT_GAIN]))
      else $error("voltage or current gain mixed up");

   rms_offsets_a: assert property (
      compute_start |=> applied.phase_a_fund_current_rms_offset == $past(bank_reg[SLOT_IFRMSOS])
      && applied.phase_a_voltage_rms_offset == $past(bank_reg[SLOT_VRMSOS]))
      else $error("rms offset routed wrongly");

   fast_offsets_a: assert property (
      reg_wr_en && reg_addr == OFFSETS[SLOT_IRMS1012OS] ##1 compute_start
      |=> applied.phase_a_multicycle_current_rms_offset == $past(reg_wr_data, 2))
      else $error("multicycle offset not carried");

   power_offsets_a: assert property (
      compute_start |=> applied.phase_a_fund_reactive_power_offset == $past(bank_reg[SLOT_FVAROS])
      && applied.phase_a_active_power_offset == $past(bank_reg[SLOT_WATTOS]))
      else $error("power offset routed wrongly");

   hold_between_a: assert property (
      !compute_start |=> $stable(applied))
      else $error("applied values changed without a computation");

   read_back_a: assert property (
      reg_wr_en && reg_addr == OFFSETS[SLOT_VGAIN] ##1 reg_rd_en && reg_addr == OFFSETS[SLOT_VGAIN]
      |=> reg_rd_data == $past(reg_wr_data, 2))
      else $error("read back mismatch");

   mp_on_c: cover property (compute_start && multipoint_enable ##1 region_reg[0] != 3'd0);
   mp_top_c: cover property (compute_start && region_reg[1] == 3'd5);
   mp_fall_c: cover property (compute_start && region_reg[0] == 3'd1 ##1 region_reg[0] == 3'd0);
   write_use_c: cover property (reg_wr_en ##1 compute_start);

endmodule : pcr_phase_calibration_regs

// ===== rtl/pcr_pkg.sv
// package: offsets, slots, reset values and carriers of the phase calibration bank
package pcr_pkg;
   localparam int ADDR_W = 10;
   localparam int DATA_W = 32;
   localparam int NUM_SLOTS = 37;
   localparam int NUM_THR = 5;
   localparam int NUM_PCORR = 5;
   localparam int NUM_MGAIN = 6;
   // slot positions inside the bank
   localparam int SLOT_PCORR0 = 0;
   localparam int SLOT_VGAIN = 5;
   localparam int SLOT_IRMSOS = 6;
   localparam int SLOT_VRMSOS = 7;
   localparam int SLOT_PGAIN = 8;
   localparam int SLOT_WATTOS = 9;
   localparam int SLOT_VAROS = 10;
   localparam int SLOT_FWATTOS = 11;
   localparam int SLOT_FVAROS = 12;
   localparam int SLOT_IFRMSOS = 13;
   localparam int SLOT_VFRMSOS = 14;
   localparam int SLOT_VRMSONEOS = 15;
   localparam int SLOT_IRMSONEOS = 16;
   localparam int SLOT_VRMS1012OS = 17;
   localparam int SLOT_IRMS1012OS = 18;
   localparam int SLOT_PHASE_B_CURRENT_GAIN = 19;
   localparam int SLOT_MGAIN0 = 20;
   localparam int SLOT_CONFIG = 26;
   localparam int SLOT_THR_LO0 = 27;
   localparam int SLOT_THR_HI0 = 32;
   // word offsets, one per slot, in slot order
   localparam logic [ADDR_W-1:0] OFFSETS [NUM_SLOTS] = '{
      10'h006, 10'h007, 10'h008, 10'h009, 10'h00A, // phase_a_phase_corr_0..4
      10'h00B, 10'h00C, 10'h00D, 10'h00E, 10'h00F, // vgain, irmsos, vrmsos, pgain, wattos
      10'h010, 10'h011, 10'h012, 10'h013, 10'h014, // varos, fwattos, fvaros, ifrmsos, vfrmsos
      10'h015, 10'h016, 10'h017, 10'h018, 10'h020, // half-cycle, multicycle offsets, phase_b_current_gain
      10'h021, 10'h022, 10'h023, 10'h024, 10'h025, // phase_b_multipoint_gain_0..4
      10'h10B,                                     // phase_b_multipoint_gain_5
      10'h100,                                     // main_config_register
      10'h101, 10'h102, 10'h103, 10'h104, 10'h105, // multipoint_low_threshold 0..4
      10'h106, 10'h107, 10'h108, 10'h109, 10'h10A  // multipoint_high_threshold 0..4
   };
   localparam logic [ADDR_W-1:0] OFF_STATUS = 10'h10C;
   localparam logic [DATA_W-1:0] RESET_VAL = 32'h0000_0000;
   localparam int CFG_MULTIPOINT_ENABLE_BIT = 0;

   typedef logic [2:0] pcr_region_t;

   // calibration values handed to the metering datapath
   typedef struct packed {
      logic [DATA_W-1:0] phase_a_phase_corr;
      logic [DATA_W-1:0] phase_a_voltage_gain;
      logic [DATA_W-1:0] phase_a_current_rms_offset;
      logic [DATA_W-1:0] phase_a_voltage_rms_offset;
      logic [DATA_W-1:0] phase_a_power_gain;
      logic [DATA_W-1:0] phase_a_active_power_offset;
      logic [DATA_W-1:0] phase_a_reactive_power_offset;
      logic [DATA_W-1:0] phase_a_fund_active_power_offset;
      logic [DATA_W-1:0] phase_a_fund_reactive_power_offset;
      logic [DATA_W-1:0] phase_a_fund_current_rms_offset;
      logic [DATA_W-1:0] phase_a_fund_voltage_rms_offset;
      logic [DATA_W-1:0] phase_a_half_cycle_voltage_rms_offset;
      logic [DATA_W-1:0] phase_a_half_cycle_current_rms_offset;
      logic [DATA_W-1:0] phase_a_multicycle_voltage_rms_offset;
      logic [DATA_W-1:0] phase_a_multicycle_current_rms_offset;
      logic [DATA_W-1:0] phase_b_current_gain;
      logic [DATA_W-1:0] phase_b_multipoint_gain;
   } pcr_applied_s;
endpackage : pcr_pkg
